// *** hw/swm_pkg.sv ***
package swm_pkg;
    localparam int CLK_MHZ          = 50;
    localparam int RST_LOW_US       = 480;
    localparam int RST_LOW_FAST_US  = 48;
    localparam int RST_LONG_MAX_US  = 960;
    localparam int PRES_WAIT_US     = 70;
    localparam int PRES_WAIT_FAST_US = 8;
    localparam int SLOT_US          = 65;
    localparam int SLOT_FAST_US     = 8;
    localparam int LOW1_US          = 6;
    localparam int LOW1_FAST_US     = 1;
    localparam int SAMPLE_US        = 12;
    localparam int SAMPLE_FAST_US   = 2;
    localparam int REC_US           = 5;
    localparam int REC_FAST_US      = 2;
    localparam int RST_LOW_CYC      = RST_LOW_US * CLK_MHZ;
    localparam int RST_LOW_FAST_CYC = RST_LOW_FAST_US * CLK_MHZ;
    localparam int PRES_WAIT_CYC    = PRES_WAIT_US * CLK_MHZ;
    localparam int PRES_WAIT_FAST_CYC = PRES_WAIT_FAST_US * CLK_MHZ;
    localparam int SLOT_CYC         = SLOT_US * CLK_MHZ;
    localparam int SLOT_FAST_CYC    = SLOT_FAST_US * CLK_MHZ;
    localparam int LOW1_CYC         = LOW1_US * CLK_MHZ;
    localparam int LOW1_FAST_CYC    = LOW1_FAST_US * CLK_MHZ;
    localparam int SAMPLE_CYC       = SAMPLE_US * CLK_MHZ;
    localparam int SAMPLE_FAST_CYC  = SAMPLE_FAST_US * CLK_MHZ;
    localparam int REC_CYC          = REC_US * CLK_MHZ;
    localparam int REC_FAST_CYC     = REC_FAST_US * CLK_MHZ;
    localparam logic [7:0] CMD_SKIP      = 8'hcc;
    localparam logic [7:0] CMD_FAST_SKIP = 8'h3c;
    localparam logic [7:0] CMD_WRITE     = 8'h55;
    localparam logic [7:0] CMD_READ      = 8'haa;
    localparam logic [7:0] CMD_CONVERT   = 8'h3c;
    localparam logic [7:0] CONV_DONE     = 8'hff;
    localparam logic [15:0] CRC16_POLY_R = 16'ha001;
    localparam logic [7:0]  CRC8_POLY_R  = 8'h8c;
    typedef enum logic [1:0] {
        SWM_OP_RESET,
        SWM_OP_WRITE,
        SWM_OP_READ
    } swm_op_e;
endpackage

// *** hw/swm_crc_if.sv ***
`timescale 1ns/1ps
interface swm_crc_if;
    logic        clear;
    logic        load;
    logic [15:0] load_val;
    logic        shift;
    logic        bit_val;
    logic [15:0] crc16;
    logic [7:0]  crc8;
    modport ctl (output clear, output load, output load_val, output shift,
                 output bit_val, input crc16, input crc8);
    modport gen (input clear, input load, input load_val, input shift,
                 input bit_val, output crc16, output crc8);
endinterface

// *** hw/swm_crc.sv ***
`timescale 1ns/1ps
module swm_crc (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    swm_crc_if.gen    crc_if
);
    logic [15:0] crc16_ff;
    logic [15:0] nxt_crc16;
    logic [7:0]  crc8_ff;
    logic [7:0]  nxt_crc8;

    always_comb begin
        nxt_crc16 = crc16_ff;
        nxt_crc8  = crc8_ff;
        if (crc_if.clear) begin
            nxt_crc16 = 16'h0000;
            nxt_crc8  = 8'h00;
        end else if (crc_if.load) begin
            nxt_crc16 = crc_if.load_val;
        end else if (crc_if.shift) begin
            nxt_crc16 = {1'b0, crc16_ff[15:1]} ^
                ((crc16_ff[0] ^ crc_if.bit_val) ? swm_pkg::CRC16_POLY_R : 16'h0000);
            nxt_crc8  = {1'b0, crc8_ff[7:1]} ^
                ((crc8_ff[0] ^ crc_if.bit_val) ? swm_pkg::CRC8_POLY_R : 8'h00);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crc16_ff <= 16'h0000;
            crc8_ff  <= 8'h00;
        end else begin
            crc16_ff <= nxt_crc16;
            crc8_ff  <= nxt_crc8;
        end
    end

    assign crc_if.crc16 = crc16_ff;
    assign crc_if.crc8  = crc8_ff;
endmodule

// *** hw/swm_master.sv ***
`timescale 1ns/1ps
module swm_master (
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic       req_in,
    input  wire logic [1:0] op_in,
    input  wire logic       long_rst_in,
    input  wire logic [7:0] wr_byte_in,
    input  wire logic       crc_clear_in,
    input  wire logic       crc_load_in,
    input  wire logic [15:0] crc_load_val_in,
    input  wire logic       crc_en_in,
    input  wire logic       line_in,
    output logic            line_out,
    output logic            line_oe_n_out,
    output logic            busy_out,
    output logic            done_out,
    output logic [7:0]      rd_byte_out,
    output logic            presence_out,
    output logic            fast_mode_flag_out,
    output logic [15:0]     crc16_out,
    output logic [7:0]      crc8_out
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RST_LOW, ST_RST_WAIT, ST_SLOT_LOW, ST_SLOT_REL, ST_REC, ST_FIN
    } swm_state_e;

    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    logic [2:0]  line_sync_ff;
    logic        line_q_ff;
    logic        nxt_line_q;
    swm_state_e  state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [2:0]  bit_ff, nxt_bit;
    logic [7:0]  sh_ff, nxt_sh;
    logic        rd_ff, nxt_rd;
    logic        crc_en_ff, nxt_crc_en;
    logic        long_ff, nxt_long;
    logic        fast_ff, nxt_fast;
    logic        pres_ff, nxt_pres;
    logic        busy_ff, nxt_busy;
    logic        done_ff, nxt_done;
    logic        drive_ff, nxt_drive;
    logic [7:0]  rdb_ff, nxt_rdb;
    logic        wr_fast_ff, nxt_wr_fast;
    logic [15:0] crc16_ff;
    logic [7:0]  crc8_ff;
    logic        smp_bit;

    swm_crc_if crc_if ();

    swm_crc u_crc (
        .clk_in   (clock_in),
        .rst_n_in (rst_n),
        .crc_if   (crc_if)
    );

    function automatic logic [15:0] pick(input logic f, input int reg_c, input int fast_c);
        pick = f ? 16'(fast_c) : 16'(reg_c);
    endfunction

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    always_comb begin
        nxt_line_q = line_q_ff;
        if (line_sync_ff[2] == line_sync_ff[1]) begin
            nxt_line_q = line_sync_ff[1];
        end
    end

    assign smp_bit = line_q_ff;
    assign crc_if.clear    = crc_clear_in && (state_ff == ST_IDLE) && req_in;
    assign crc_if.load     = crc_load_in && (state_ff == ST_IDLE) && req_in;
    assign crc_if.load_val = crc_load_val_in;
    assign crc_if.shift    = crc_en_ff && (state_ff == ST_REC) && (cnt_ff == 16'h0000);
    assign crc_if.bit_val  = rd_ff ? sh_ff[7] : sh_ff[0];

    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_bit    = bit_ff;
        nxt_sh     = sh_ff;
        nxt_rd     = rd_ff;
        nxt_crc_en = crc_en_ff;
        nxt_long   = long_ff;
        nxt_fast   = fast_ff;
        nxt_pres   = pres_ff;
        nxt_busy   = busy_ff;
        nxt_done   = 1'b0;
        nxt_drive  = drive_ff;
        nxt_rdb    = rdb_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req_in) begin
                    nxt_busy   = 1'b1;
                    nxt_bit    = 3'h0;
                    nxt_sh     = wr_byte_in;
                    nxt_crc_en = crc_en_in;
                    nxt_drive  = 1'b1;
                    if (op_in == swm_pkg::SWM_OP_RESET) begin
                        nxt_long  = long_rst_in || !fast_ff;
                        nxt_cnt   = nxt_long ? 16'(swm_pkg::RST_LOW_CYC)
                                             : 16'(swm_pkg::RST_LOW_FAST_CYC);
                        nxt_state = ST_RST_LOW;
                    end else begin
                        nxt_rd    = (op_in == swm_pkg::SWM_OP_READ);
                        nxt_state = ST_SLOT_LOW;
                        nxt_cnt   = pick(fast_ff, swm_pkg::LOW1_CYC, swm_pkg::LOW1_FAST_CYC);
                        if (op_in == swm_pkg::SWM_OP_WRITE && !wr_byte_in[0]) begin
                            nxt_cnt = pick(fast_ff, swm_pkg::SLOT_CYC, swm_pkg::SLOT_FAST_CYC);
                        end
                    end
                end
            end
            ST_RST_LOW: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_drive = 1'b0;
                    if (long_ff) begin
                        nxt_fast = 1'b0;
                    end
                    nxt_pres  = 1'b0;
                    nxt_cnt   = pick(nxt_fast, swm_pkg::PRES_WAIT_CYC + swm_pkg::SLOT_CYC * 4,
                                     swm_pkg::PRES_WAIT_FAST_CYC + swm_pkg::SLOT_FAST_CYC * 3);
                    nxt_state = ST_RST_WAIT;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            ST_RST_WAIT: begin
                if (!line_q_ff) begin
                    nxt_pres = 1'b1;
                end
                if (cnt_ff == 16'h0000) begin
                    nxt_state = ST_FIN;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            ST_SLOT_LOW: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_drive = 1'b0;
                    nxt_cnt   = pick(fast_ff, swm_pkg::SAMPLE_CYC - swm_pkg::LOW1_CYC,
                                     swm_pkg::SAMPLE_FAST_CYC - swm_pkg::LOW1_FAST_CYC);
                    nxt_state = ST_SLOT_REL;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            ST_SLOT_REL: begin
                if (cnt_ff == 16'h0000) begin
                    if (rd_ff) begin
                        nxt_sh = {smp_bit, sh_ff[7:1]};
                    end
                    nxt_cnt   = pick(fast_ff, swm_pkg::SLOT_CYC + swm_pkg::REC_CYC,
                                     swm_pkg::SLOT_FAST_CYC + swm_pkg::REC_FAST_CYC);
                    nxt_state = ST_REC;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            ST_REC: begin
                if (cnt_ff == 16'h0000) begin
                    if (!rd_ff) begin
                        nxt_sh = {1'b0, sh_ff[7:1]};
                    end
                    if (bit_ff == 3'h7) begin
                        nxt_state = ST_FIN;
                        if (rd_ff) begin
                            nxt_rdb = sh_ff;
                        end
                    end else begin
                        nxt_bit   = bit_ff + 3'h1;
                        nxt_drive = 1'b1;
                        nxt_cnt   = pick(fast_ff, swm_pkg::LOW1_CYC, swm_pkg::LOW1_FAST_CYC);
                        if (!rd_ff && !sh_ff[1]) begin
                            nxt_cnt = pick(fast_ff, swm_pkg::SLOT_CYC, swm_pkg::SLOT_FAST_CYC);
                        end
                        nxt_state = ST_SLOT_LOW;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            ST_FIN: begin
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
                nxt_state = ST_IDLE;
                if (!rd_ff && op_in != swm_pkg::SWM_OP_RESET && sh_ff == 8'h00
                    && bit_ff == 3'h7 && wr_fast_ff) begin
                    nxt_fast = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        nxt_wr_fast = wr_fast_ff;
        if (state_ff == ST_IDLE && req_in) begin
            nxt_wr_fast = (op_in == swm_pkg::SWM_OP_WRITE) && (wr_byte_in == swm_pkg::CMD_FAST_SKIP)
                          && long_rst_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            line_sync_ff <= 3'h7;
            line_q_ff    <= 1'b1;
            state_ff     <= ST_IDLE;
            cnt_ff       <= 16'h0000;
            bit_ff       <= 3'h0;
            sh_ff        <= 8'h00;
            rd_ff        <= 1'b0;
            crc_en_ff    <= 1'b0;
            long_ff      <= 1'b1;
            fast_ff      <= 1'b0;
            pres_ff      <= 1'b0;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b0;
            drive_ff     <= 1'b0;
            rdb_ff       <= 8'h00;
            wr_fast_ff   <= 1'b0;
            crc16_ff     <= 16'h0000;
            crc8_ff      <= 8'h00;
        end else begin
            line_sync_ff <= {line_sync_ff[1:0], line_in};
            line_q_ff    <= nxt_line_q;
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            bit_ff       <= nxt_bit;
            sh_ff        <= nxt_sh;
            rd_ff        <= nxt_rd;
            crc_en_ff    <= nxt_crc_en;
            long_ff      <= nxt_long;
            fast_ff      <= nxt_fast;
            pres_ff      <= nxt_pres;
            busy_ff      <= nxt_busy;
            done_ff      <= nxt_done;
            drive_ff     <= nxt_drive;
            rdb_ff       <= nxt_rdb;
            wr_fast_ff   <= nxt_wr_fast;
            crc16_ff     <= ~crc_if.crc16;
            crc8_ff      <= crc_if.crc8;
        end
    end

    assign line_out           = 1'b0;
    assign line_oe_n_out      = !drive_ff;
    assign busy_out           = busy_ff;
    assign done_out           = done_ff;
    assign rd_byte_out        = rdb_ff;
    assign presence_out       = pres_ff;
    assign fast_mode_flag_out = fast_ff;
    assign crc16_out          = crc16_ff;
    assign crc8_out           = crc8_ff;
endmodule

// *** testbench/swm_master_properties.sv ***
`timescale 1ns/1ps
module swm_master_props (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic req_in,
    input wire logic busy_out,
    input wire logic line_oe_n_out,
    input wire logic presence_out,
    input wire logic fast_mode_flag_out
);
    logic [16:0] low_ff, nxt_low, last_ff, nxt_last;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // Length of the current and the last master low phase
    always_comb begin
        nxt_low = line_oe_n_out ? 17'h00000 : low_ff + 17'h00001;
        nxt_last = (line_oe_n_out && low_ff != 17'h00000) ? low_ff : last_ff;
    end
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_ff <= 17'h00000;
            last_ff <= 17'h00000;
        end else begin
            low_ff <= nxt_low;
            last_ff <= nxt_last;
        end
    end
    property p_start;
        req_in && !busy_out |=> busy_out ##[0:1] !line_oe_n_out;
    endproperty
    a_start: assert property (p_start) else $error("slot start late");
    property p_rst_reg;
        $rose(line_oe_n_out) && !fast_mode_flag_out && low_ff > 17'h01964
            |-> low_ff >= 17'(swm_pkg::RST_LOW_CYC);
    endproperty
    a_rst_reg: assert property (p_rst_reg) else $error("reset too short");
    property p_rst_fast;
        $rose(line_oe_n_out) && fast_mode_flag_out && low_ff > 17'h00320
            |-> low_ff >= 17'(swm_pkg::RST_LOW_FAST_CYC);
    endproperty
    a_rst_fast: assert property (p_rst_fast) else $error("fast reset short");
    property p_rst_max;
        $rose(line_oe_n_out) |-> low_ff < 17'(swm_pkg::RST_LONG_MAX_US * swm_pkg::CLK_MHZ);
    endproperty
    a_rst_max: assert property (p_rst_max) else $error("reset too long");
    property p_rec;
        $rose(line_oe_n_out) |=> line_oe_n_out [*8];
    endproperty
    a_rec: assert property (p_rec) else $error("no recovery");
    property p_fast_chg;
        $changed(fast_mode_flag_out) |-> $past(busy_out);
    endproperty
    a_fast_chg: assert property (p_fast_chg) else $error("speed changed idle");
    property p_fast_exit;
        $fell(fast_mode_flag_out) |-> low_ff >= 17'(swm_pkg::RST_LOW_CYC);
    endproperty
    a_fast_exit: assert property (p_fast_exit) else $error("fast left early");
    property p_pres;
        $rose(presence_out) |-> last_ff >= 17'(swm_pkg::RST_LOW_FAST_CYC);
    endproperty
    a_pres: assert property (p_pres) else $error("presence no reset");
endmodule
bind swm_master swm_master_props u_props (.clock_in(clock_in), .nrst_in(nrst_in),
    .req_in(req_in), .busy_out(busy_out), .line_oe_n_out(line_oe_n_out),
    .presence_out(presence_out), .fast_mode_flag_out(fast_mode_flag_out));

// *** testbench/swm_dev_model.sv ***
`timescale 1ns/1ps
module swm_dev_model (
    input  wire logic       line_in,
    input  wire logic       slow_in,
    input  wire logic       tx_en_in,
    input  wire logic [7:0] tx_byte_in,
    output logic            pull_low_out,
    output logic [7:0]      rx_byte_out,
    output logic            fast_out
);
    realtime t_fall, low_us;
    bit      armed, in_pres;
    int      n_bits;
    initial begin
        pull_low_out = 1'b0;
        rx_byte_out = 8'h00;
        fast_out = 1'b0;
        armed = 1'b0;
        in_pres = 1'b0;
        n_bits = 0;
    end
    // Slot start; zero bits of a read byte held low
    always @(negedge line_in) begin
        if (!in_pres) begin
            t_fall = $realtime;
            armed = 1'b1;
            if (tx_en_in && !tx_byte_in[n_bits % 8]) begin
                pull_low_out = 1'b1;
                #((fast_out ? 3.0 : 15.0) * 1000.0);
                pull_low_out = 1'b0;
            end
        end
    end
    // Slot end or reset end
    always @(posedge line_in) begin
        if (armed && !in_pres) begin
            armed = 1'b0;
            low_us = ($realtime - t_fall) / 1000.0;
            if (low_us >= (fast_out ? 40.0 : 400.0)) begin
                in_pres = 1'b1;
                n_bits = 0;
                if (low_us >= 479.0) begin
                    fast_out = 1'b0;
                end
                #((fast_out ? (slow_in ? 6.0 : 2.0) : (slow_in ? 60.0 : 15.0)) * 1000.0);
                pull_low_out = 1'b1;
                #((fast_out ? (slow_in ? 24.0 : 8.0) : (slow_in ? 240.0 : 60.0)) * 1000.0);
                pull_low_out = 1'b0;
                #1;
                in_pres = 1'b0;
            end else begin
                rx_byte_out = {low_us < (fast_out ? 3.0 : 30.0), rx_byte_out[7:1]};
                n_bits++;
                if (n_bits == 8 && rx_byte_out == 8'h3c) begin
                    fast_out = 1'b1;
                end
            end
        end
    end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic        clock_in, nrst_in, req_in, long_rst_in, crc_clear_in, crc_load_in, crc_en_in;
    logic [1:0]  op_in;
    logic [7:0]  wr_byte_in, rd_byte_out, crc8_out, tx_byte, dev_rx;
    logic [15:0] crc_load_val_in, crc16_out;
    logic        line_out, line_oe_n_out, busy_out, done_out, presence_out;
    logic        fast_mode_flag_out, pull_low, slow, tx_en, dev_fast;
    wire         line_w;
    int          n_fail, total_checks, cycles;
    // Pulled-up line, low when either side pulls it
    assign line_w = !((line_oe_n_out === 1'b0 && line_out === 1'b0) || pull_low === 1'b1);
    swm_master uut (.clock_in, .nrst_in, .req_in, .op_in, .long_rst_in, .wr_byte_in,
        .crc_clear_in, .crc_load_in, .crc_load_val_in, .crc_en_in, .line_in(line_w),
        .line_out, .line_oe_n_out, .busy_out, .done_out, .rd_byte_out, .presence_out,
        .fast_mode_flag_out, .crc16_out, .crc8_out);
    swm_dev_model dev (.line_in(line_w), .slow_in(slow), .tx_en_in(tx_en),
        .tx_byte_in(tx_byte), .pull_low_out(pull_low), .rx_byte_out(dev_rx),
        .fast_out(dev_fast));
    always #10 clock_in = ~clock_in;
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b,
                                        input logic [15:0] poly);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ b[i]) ? (r >> 1) ^ poly : r >> 1;
        end
        return r;
    endfunction
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done();
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic run_op(input logic [1:0] op, input logic lng, input logic [7:0] b,
                          input logic [2:0] ctl, input logic [15:0] lv);
        int n;
        n = 0;
        @(posedge clock_in);
        req_in <= 1'b1;
        op_in <= op;
        long_rst_in <= lng;
        wr_byte_in <= b;
        {crc_clear_in, crc_load_in, crc_en_in} <= ctl;
        crc_load_val_in <= lv;
        @(posedge clock_in);
        req_in <= 1'b0;
        crc_clear_in <= 1'b0;
        crc_load_in <= 1'b0;
        while (done_out !== 1'b1 && n < 60000) begin
            @(negedge clock_in);
            n++;
        end
        check("done", 16'h0001, 16'(done_out));
        repeat (3) @(posedge clock_in);
    endtask
    task automatic t_fast_skip();
        run_op(2'(swm_pkg::SWM_OP_WRITE), 1'b1, 8'h3c, 3'h5, 16'h0000);
        check("dev_rx", 16'h003c, 16'(dev_rx));
        check("fast_flag", 16'h0001, 16'(fast_mode_flag_out));
        check("dev_fast", 16'h0001, 16'(dev_fast));
        check("crc16", ~crc(16'h0000, 8'h3c, 16'ha001), crc16_out);
    endtask
    task automatic t_wr_rd();
        logic [15:0] c;
        run_op(2'(swm_pkg::SWM_OP_WRITE), 1'b0, 8'h55, 3'h5, 16'h0000);
        check("dev_rx", 16'h0055, 16'(dev_rx));
        tx_byte <= 8'ha5;
        tx_en <= 1'b1;
        run_op(2'(swm_pkg::SWM_OP_READ), 1'b0, 8'hff, 3'h1, 16'h0000);
        tx_en <= 1'b0;
        check("rd_byte", 16'h00a5, 16'(rd_byte_out));
        c = crc(crc(16'h0000, 8'h55, 16'ha001), 8'ha5, 16'ha001);
        check("crc16", ~c, crc16_out);
        c = crc(crc(16'h0000, 8'h55, 16'h008c), 8'ha5, 16'h008c);
        check("crc8", c, 16'(crc8_out));
        run_op(2'(swm_pkg::SWM_OP_WRITE), 1'b0, 8'h96, 3'h3, 16'h0017);
        check("crc16_load", ~crc(16'h0017, 8'h96, 16'ha001), crc16_out);
    endtask
    task automatic t_short_rst();
        slow <= 1'b0;
        run_op(2'(swm_pkg::SWM_OP_RESET), 1'b0, 8'h00, 3'h0, 16'h0000);
        check("presence", 16'h0001, 16'(presence_out));
        check("fast_flag", 16'h0001, 16'(fast_mode_flag_out));
    endtask
    task automatic t_long_rst();
        slow <= 1'b1;
        run_op(2'(swm_pkg::SWM_OP_RESET), 1'b1, 8'h00, 3'h0, 16'h0000);
        check("presence", 16'h0001, 16'(presence_out));
        check("fast_flag", 16'h0000, 16'(fast_mode_flag_out));
        check("dev_fast", 16'h0000, 16'(dev_fast));
    endtask
    // Hang guard
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 130000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        clock_in = 1'b0;
        nrst_in = 1'b0;
        req_in = 1'b0;
        op_in = 2'h0;
        long_rst_in = 1'b0;
        wr_byte_in = 8'h00;
        {crc_clear_in, crc_load_in, crc_en_in} = 3'h0;
        crc_load_val_in = 16'h0000;
        {slow, tx_en} = 2'h0;
        tx_byte = 8'h00;
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        repeat (6) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        t_fast_skip();
        t_wr_rd();
        t_short_rst();
        t_long_rst();
        test_done();
    end
endmodule
